// [ppe_port.sv]
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Offset 3 access runs an EPP address cycle with automatic address strobe.
// - Offsets 4 to 7 run an EPP data cycle with automatic data strobe.
// - Outside EPP and FIFO handshakes, strobe, auto-feed and init follow port_control; direction too, except in mode 000, which always drives.
// - An EPP write with direction reverse runs a read cycle, no error.
// - EPP cycle over 10 ms sets timeout; later cycles abort until status written.
// - Mode 000 is compatibility, mode 001 is byte mode.
// - Offset 400h maps per mode; extended_control at 402h always.
// - Offsets 0 to 2 are reachable in every mode.
// - All FIFO modes share one 16-byte FIFO.
// - In mode 011 with direction forward, writes at offset 0 enter the FIFO as address bytes.
// - Auto-feed low while an address byte is on the lines, high for data.
// - Mode 010 sends FIFO bytes by compatibility handshake.
// - Mode 011 exchanges FIFO bytes by ECP handshake, direction picks the way.
// - Mode 110 test FIFO is reached from the bus with no port handshake.
// - Test FIFO drops writes when full, re-reads when empty; flags stay true.
// - Mode 111: 400h reads 10h, 401h reads interrupt line in bit 6.
// - extended_control holds mode, error enable, DMA enable, service, full, empty.
// - Entering mode 000 or 001 resets FIFO pointers, keeps contents.
// - Mode 011 reverse moves bytes from the port input lines into the FIFO.
// - With error enable bit zero, a falling fault line raises an error interrupt.
// - Service clear and DMA enabled: terminal count sets the service bit.
module ppe_port #(
  parameter int EPP_TIMEOUT_CYCLES = ppe_pkg::EPP_TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire ppe_pkg::ppe_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire ppe_pkg::ppe_pins_t pins_i,
  output ppe_pkg::ppe_ctl_pins_t ctl_pins_o,
  output logic [7:0] port_data_out_o,
  output logic port_data_oe_o,
  input wire logic dma_tc_i,
  output logic dma_req_o,
  output logic error_irq_o
);

  ppe_pkg::ppe_pins_t pins_meta_q;
  ppe_pkg::ppe_pins_t pins_q;
  logic [7:0] ctrl_q;
  logic [7:0] ecr_q;
  logic [7:0] data_q;
  logic timeout_q;
  ppe_pkg::ppe_state_t state_q;
  logic [31:0] epp_cnt_q;
  logic epp_write_q;
  logic epp_addr_q;
  logic [7:0] epp_rd_q;
  logic [7:0] xfer_q;
  logic xfer_tag_q;
  logic [8:0] mem_q [ppe_pkg::FIFO_DEPTH];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [4:0] count_q;
  logic fault_prev_q;

  logic [2:0] mode;
  logic dir;
  logic full;
  logic empty;
  logic hit_fifo;
  logic epp_access;
  logic bus_push;
  logic bus_pop;
  logic eng_pop;
  logic rev_push;
  logic push;
  logic pop;
  logic [8:0] push_word;
  logic ptr_reset;
  logic epp_done;

  function automatic logic addr_is(input logic [10:0] a, input logic [10:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  assign mode = ecr_q[ppe_pkg::ECR_MODE_LSB +: 3];
  assign dir = ctrl_q[ppe_pkg::CTRL_DIR];
  assign full = (count_q == ppe_pkg::FIFO_FULL_CNT);
  assign empty = (count_q == '0);
  assign hit_fifo = addr_is(bus_i.addr, ppe_pkg::OFS_FIFO);
  assign epp_access = (bus_i.wr || bus_i.rd) && (bus_i.addr >= ppe_pkg::OFS_EPP_ADDR)
    && (bus_i.addr <= ppe_pkg::OFS_EPP_DATA_HI);

  // Bus side of the shared FIFO; the reverse ECP direction owns the push side.
  always_comb
  begin
    bus_push = 1'b0;
    bus_pop = 1'b0;
    push_word = {1'b0, bus_i.wdata};
    if (bus_i.wr && hit_fifo && (mode == ppe_pkg::MODE_COMPAT_FIFO || mode == ppe_pkg::MODE_TEST
        || (mode == ppe_pkg::MODE_ECP && !dir)))
    begin
      bus_push = 1'b1;
    end
    if (bus_i.wr && addr_is(bus_i.addr, ppe_pkg::OFS_DATA) && mode == ppe_pkg::MODE_ECP && !dir)
    begin
      bus_push = 1'b1;
      push_word = {1'b1, bus_i.wdata};
    end
    if (bus_i.rd && hit_fifo && (mode == ppe_pkg::MODE_TEST || (mode == ppe_pkg::MODE_ECP && dir)))
    begin
      bus_pop = 1'b1;
    end
    if (rev_push)
    begin
      push_word = {1'b0, pins_q.port_data_in};
    end
  end

  assign eng_pop = (state_q == ppe_pkg::ST_IDLE) && !empty && !dir && !epp_access
    && (mode == ppe_pkg::MODE_COMPAT_FIFO || mode == ppe_pkg::MODE_ECP);
  assign rev_push = (state_q == ppe_pkg::ST_IDLE) && mode == ppe_pkg::MODE_ECP && dir
    && !full && !pins_q.acknowledge_n && !epp_access;
  assign push = (bus_push || rev_push) && !full;
  assign pop = (bus_pop || eng_pop) && !empty;
  assign ptr_reset = bus_i.wr && addr_is(bus_i.addr, ppe_pkg::OFS_ECR)
    && (bus_i.wdata[ppe_pkg::ECR_MODE_LSB +: 3] == ppe_pkg::MODE_COMPAT
    || bus_i.wdata[ppe_pkg::ECR_MODE_LSB +: 3] == ppe_pkg::MODE_BYTE);
  assign epp_done = (state_q == ppe_pkg::ST_EPP) && pins_q.busy_n;

  // Port pins cross in from the peripheral through two flip-flops.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pins_meta_q <= '0;
      pins_q <= '0;
      fault_prev_q <= 1'b0;
    end
    else
    begin
      pins_meta_q <= pins_i;
      pins_q <= pins_meta_q;
      fault_prev_q <= pins_q.fault_n;
    end
  end

  // Single shared FIFO, one count for all modes.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (ptr_reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      count_q <= count_q + {4'h0, push} - {4'h0, pop};
    end
  end

  // Contents are left alone by pointer resets and by reset itself.
  always_ff @(posedge clock_i)
  begin
    if (push && !ptr_reset)
    begin
      mem_q[wr_ptr_q] <= push_word;
    end
  end

  // Software registers.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= ppe_pkg::CTRL_RESET;
      ecr_q <= ppe_pkg::ECR_RESET;
      data_q <= 8'h00;
    end
    else
    begin
      if (bus_i.wr && addr_is(bus_i.addr, ppe_pkg::OFS_CTRL))
      begin
        ctrl_q <= bus_i.wdata & ppe_pkg::CTRL_WMASK;
      end
      if (bus_i.wr && addr_is(bus_i.addr, ppe_pkg::OFS_DATA) && mode != ppe_pkg::MODE_ECP)
      begin
        data_q <= bus_i.wdata;
      end
      else if (bus_i.wr && hit_fifo && mode == ppe_pkg::MODE_TEST)
      begin
        data_q <= bus_i.wdata;
      end
      if (bus_i.wr && addr_is(bus_i.addr, ppe_pkg::OFS_ECR))
      begin
        ecr_q[7:ppe_pkg::ECR_SERVICE] <= bus_i.wdata[7:ppe_pkg::ECR_SERVICE];
      end
      if (dma_tc_i && ecr_q[ppe_pkg::ECR_DMA_EN] && !ecr_q[ppe_pkg::ECR_SERVICE])
      begin
        ecr_q[ppe_pkg::ECR_SERVICE] <= 1'b1;
      end
    end
  end

  // EPP timeout flag; a timeout in the clearing cycle still lands.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      timeout_q <= 1'b0;
    end
    else if (state_q == ppe_pkg::ST_EPP && !pins_q.busy_n && epp_cnt_q >= 32'(EPP_TIMEOUT_CYCLES - 1))
    begin
      timeout_q <= 1'b1;
    end
    else if (bus_i.wr && addr_is(bus_i.addr, ppe_pkg::OFS_STAT))
    begin
      timeout_q <= 1'b0;
    end
  end

  // Port handshake engine.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ppe_pkg::ST_IDLE;
      epp_cnt_q <= '0;
      epp_write_q <= 1'b0;
      epp_addr_q <= 1'b0;
      epp_rd_q <= 8'h00;
      xfer_q <= 8'h00;
      xfer_tag_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ppe_pkg::ST_IDLE:
        begin
          epp_cnt_q <= '0;
          if (epp_access && !timeout_q)
          begin
            state_q <= ppe_pkg::ST_EPP;
            epp_addr_q <= addr_is(bus_i.addr, ppe_pkg::OFS_EPP_ADDR);
            epp_write_q <= bus_i.wr && !dir;
            xfer_q <= bus_i.wdata;
          end
          else if (eng_pop)
          begin
            state_q <= ppe_pkg::ST_FWD_STB;
            xfer_q <= mem_q[rd_ptr_q][7:0];
            xfer_tag_q <= mem_q[rd_ptr_q][8];
          end
          else if (rev_push)
          begin
            state_q <= ppe_pkg::ST_REV_ACK;
          end
        end
        ppe_pkg::ST_EPP:
        begin
          epp_cnt_q <= epp_cnt_q + 32'h0000_0001;
          if (epp_done)
          begin
            state_q <= ppe_pkg::ST_IDLE;
            if (!epp_write_q)
            begin
              epp_rd_q <= pins_q.port_data_in;
            end
          end
          else if (epp_cnt_q >= 32'(EPP_TIMEOUT_CYCLES - 1))
          begin
            state_q <= ppe_pkg::ST_IDLE;
          end
        end
        ppe_pkg::ST_FWD_STB:
        begin
          if (!pins_q.busy_n)
          begin
            state_q <= ppe_pkg::ST_FWD_REL;
          end
        end
        ppe_pkg::ST_FWD_REL:
        begin
          if (pins_q.busy_n)
          begin
            state_q <= ppe_pkg::ST_IDLE;
          end
        end
        ppe_pkg::ST_REV_ACK:
        begin
          if (pins_q.acknowledge_n)
          begin
            state_q <= ppe_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ppe_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers, registered so every pin comes from a flip-flop.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctl_pins_o <= '{data_strobe_n: 1'b1, auto_feed_n: 1'b1, init_line_n: 1'b0, select_in_n: 1'b1};
      port_data_out_o <= 8'h00;
      port_data_oe_o <= 1'b0;
    end
    else
    begin
      ctl_pins_o.data_strobe_n <= !ctrl_q[ppe_pkg::CTRL_STROBE];
      ctl_pins_o.auto_feed_n <= !ctrl_q[ppe_pkg::CTRL_AUTOFD];
      ctl_pins_o.init_line_n <= ctrl_q[ppe_pkg::CTRL_INIT];
      ctl_pins_o.select_in_n <= !ctrl_q[ppe_pkg::CTRL_SELECT_IN];
      port_data_out_o <= data_q;
      port_data_oe_o <= !dir || mode == ppe_pkg::MODE_COMPAT;
      unique case (state_q)
        ppe_pkg::ST_IDLE:
        begin
        end
        ppe_pkg::ST_EPP:
        begin
          // Write line on the strobe pin, address or data strobe on the select or feed pin.
          ctl_pins_o.data_strobe_n <= !epp_write_q;
          ctl_pins_o.select_in_n <= !epp_addr_q;
          ctl_pins_o.auto_feed_n <= epp_addr_q;
          port_data_out_o <= xfer_q;
          port_data_oe_o <= epp_write_q;
        end
        ppe_pkg::ST_FWD_STB, ppe_pkg::ST_FWD_REL:
        begin
          ctl_pins_o.data_strobe_n <= (state_q == ppe_pkg::ST_FWD_REL);
          if (mode == ppe_pkg::MODE_ECP)
          begin
            ctl_pins_o.auto_feed_n <= !xfer_tag_q;
          end
          port_data_out_o <= xfer_q;
          port_data_oe_o <= 1'b1;
        end
        ppe_pkg::ST_REV_ACK:
        begin
          ctl_pins_o.auto_feed_n <= 1'b1;
          port_data_oe_o <= 1'b0;
        end
        default:
        begin
        end
      endcase
    end
  end

  // Read data, DMA request and error interrupt.
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= 8'h00;
      dma_req_o <= 1'b0;
      error_irq_o <= 1'b0;
    end
    else
    begin
      dma_req_o <= ecr_q[ppe_pkg::ECR_DMA_EN] && !ecr_q[ppe_pkg::ECR_SERVICE]
        && (mode == ppe_pkg::MODE_COMPAT_FIFO || mode == ppe_pkg::MODE_ECP || mode == ppe_pkg::MODE_TEST)
        && (dir ? !empty : !full);
      error_irq_o <= !ecr_q[ppe_pkg::ECR_ERR_EN_N] && fault_prev_q && !pins_q.fault_n;
      rdata_o <= 8'h00;
      if (bus_i.rd)
      begin
        if (addr_is(bus_i.addr, ppe_pkg::OFS_DATA))
        begin
          rdata_o <= dir ? pins_q.port_data_in : data_q;
        end
        else if (addr_is(bus_i.addr, ppe_pkg::OFS_STAT))
        begin
          rdata_o <= {pins_q.busy_n, pins_q.acknowledge_n, pins_q.paper_out, pins_q.selected,
            pins_q.fault_n, 3'h0};
          rdata_o[ppe_pkg::STAT_TIMEOUT_BIT] <= timeout_q;
        end
        else if (addr_is(bus_i.addr, ppe_pkg::OFS_CTRL))
        begin
          rdata_o <= ctrl_q;
        end
        else if (epp_access)
        begin
          rdata_o <= epp_rd_q;
        end
        else if (hit_fifo && mode == ppe_pkg::MODE_CONFIG)
        begin
          rdata_o <= ppe_pkg::ECP_CONFIG_A_VALUE;
        end
        else if (hit_fifo)
        begin
          rdata_o <= mem_q[rd_ptr_q][7:0];
        end
        else if (addr_is(bus_i.addr, ppe_pkg::OFS_ECP_CONFIG_B) && mode == ppe_pkg::MODE_CONFIG)
        begin
          rdata_o[ppe_pkg::ECP_CONFIG_B_IRQ_BIT] <= pins_q.pin_interrupt_line;
        end
        else if (addr_is(bus_i.addr, ppe_pkg::OFS_ECR))
        begin
          rdata_o <= {ecr_q[7:ppe_pkg::ECR_SERVICE], full, empty};
        end
      end
    end
  end

endmodule : ppe_port

// [ppe_pkg.sv]
package ppe_pkg;

  localparam int ADDR_W = 11;

  // Byte offsets from the port base address.
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STAT = 11'h001;
  localparam logic [10:0] OFS_CTRL = 11'h002;
  localparam logic [10:0] OFS_EPP_ADDR = 11'h003;
  localparam logic [10:0] OFS_EPP_DATA_LO = 11'h004;
  localparam logic [10:0] OFS_EPP_DATA_HI = 11'h007;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_ECP_CONFIG_B = 11'h401;
  localparam logic [10:0] OFS_ECR = 11'h402;

  // Mode field encodings of extended_control.
  localparam logic [2:0] MODE_COMPAT = 3'h0;
  localparam logic [2:0] MODE_BYTE = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;

  // port_control bit positions.
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_AUTOFD = 1;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_SELECT_IN = 3;
  localparam int CTRL_IRQ_EN = 4;
  localparam int CTRL_DIR = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h3F;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // extended_control bit positions.
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_ERR_EN_N = 4;
  localparam int ECR_DMA_EN = 3;
  localparam int ECR_SERVICE = 2;
  localparam int ECR_FULL = 1;
  localparam int ECR_EMPTY = 0;
  localparam logic [7:0] ECR_RESET = 8'h00;

  localparam logic [7:0] ECP_CONFIG_A_VALUE = 8'h10;
  localparam int ECP_CONFIG_B_IRQ_BIT = 6;
  localparam int STAT_TIMEOUT_BIT = 0;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_PTR_W = 4;
  localparam int FIFO_CNT_W = 5;
  localparam logic [4:0] FIFO_FULL_CNT = 5'h10;

  localparam int EPP_TIMEOUT_MS = 10;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int EPP_TIMEOUT_CYC = EPP_TIMEOUT_MS * CLK_FREQ_KHZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ppe_bus_req_t;

  typedef struct packed {
    logic busy_n;
    logic acknowledge_n;
    logic paper_out;
    logic selected;
    logic fault_n;
    logic pin_interrupt_line;
    logic [7:0] port_data_in;
  } ppe_pins_t;

  typedef struct packed {
    logic data_strobe_n;
    logic auto_feed_n;
    logic init_line_n;
    logic select_in_n;
  } ppe_ctl_pins_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_EPP = 5'b00010,
    ST_FWD_STB = 5'b00100,
    ST_FWD_REL = 5'b01000,
    ST_REV_ACK = 5'b10000
  } ppe_state_t;

endpackage : ppe_pkg

// [ppe_port_chk.sv]
`timescale 1ns/1ps
module ppe_port_chk #(
  parameter int EPP_TIMEOUT_CYCLES = ppe_pkg::EPP_TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire ppe_pkg::ppe_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire ppe_pkg::ppe_pins_t pins_i,
  input wire ppe_pkg::ppe_ctl_pins_t ctl_pins_o,
  input wire logic [7:0] port_data_out_o,
  input wire logic port_data_oe_o,
  input wire logic dma_tc_i,
  input wire logic dma_req_o,
  input wire logic error_irq_o
);
  logic [7:0] ctrl_q;
  logic [7:0] ecr_q;
  logic [7:0] epp_wd_q;
  int cnt_q;
  logic epp;
  logic hold;
  logic rd_at;
  assign epp = bus_i.addr >= ppe_pkg::OFS_EPP_ADDR && bus_i.addr <= ppe_pkg::OFS_EPP_DATA_HI;
  // A strobe the control register does not ask for can only belong to a running EPP cycle.
  assign hold = (!ctl_pins_o.select_in_n && !ctrl_q[3]) ||
                (!ctl_pins_o.auto_feed_n && !ctrl_q[1] && ecr_q[7:5] != ppe_pkg::MODE_ECP);
  assign rd_at = bus_i.rd && ecr_q[7:5] == ppe_pkg::MODE_CONFIG;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= 8'h00;
      ecr_q <= 8'h00;
      epp_wd_q <= 8'h00;
    end
    else if (bus_i.wr)
    begin
      if (bus_i.addr == ppe_pkg::OFS_CTRL)
        ctrl_q <= bus_i.wdata;
      if (bus_i.addr == ppe_pkg::OFS_ECR)
        ecr_q <= bus_i.wdata;
      if (epp)
        epp_wd_q <= bus_i.wdata;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_q <= 0;
    else
      cnt_q <= hold ? cnt_q + 1 : 0;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  chk_ecp_config_a_read: assert property (
    rd_at && bus_i.addr == ppe_pkg::OFS_FIFO |=> rdata_o == ppe_pkg::ECP_CONFIG_A_VALUE)
    else $error("config A read mismatch");
  chk_ecp_config_b_read: assert property (
    rd_at && bus_i.addr == ppe_pkg::OFS_ECP_CONFIG_B |=> rdata_o[7] == 1'b0 && rdata_o[5:0] == 6'h00)
    else $error("config B read mismatch");
  chk_ecr_fields: assert property (
    bus_i.rd && bus_i.addr == ppe_pkg::OFS_ECR |=> rdata_o[7:3] == $past(ecr_q[7:3]))
    else $error("extended control readback mismatch");
  chk_flags_excl: assert property (
    bus_i.rd && bus_i.addr == ppe_pkg::OFS_ECR |=> !(rdata_o[1] && rdata_o[0]))
    else $error("full and empty both set");
  chk_ctrl_read: assert property (
    bus_i.rd && bus_i.addr == ppe_pkg::OFS_CTRL |=> rdata_o == ($past(ctrl_q) & ppe_pkg::CTRL_WMASK))
    else $error("control readback mismatch");
  chk_addr_cycle: assert property (
    $fell(ctl_pins_o.select_in_n) && !ctl_pins_o.data_strobe_n && !ctrl_q[3]
      |-> port_data_oe_o && port_data_out_o == epp_wd_q)
    else $error("address write cycle data mismatch");
  chk_rev_write: assert property (
    bus_i.wr && epp && ctrl_q[5] && !ctrl_q[0] && ecr_q[7:5] == ppe_pkg::MODE_BYTE
      |=> (!port_data_oe_o && ctl_pins_o.data_strobe_n) [*4])
    else $error("write strobe with reverse direction");
  chk_epp_timeout: assert property (
    cnt_q <= EPP_TIMEOUT_CYCLES + 8)
    else $error("EPP cycle outlived its timeout");
  chk_err_pulse: assert property (
    error_irq_o |-> (!ecr_q[4] || !$past(ecr_q[4])) ##1 !error_irq_o)
    else $error("error interrupt not a gated pulse");
  chk_dma_stop: assert property (
    dma_tc_i && dma_req_o |-> ##[1:4] !dma_req_o)
    else $error("DMA request survived terminal count");

  cov_test_read: cover property (bus_i.rd && bus_i.addr == ppe_pkg::OFS_FIFO && ecr_q[7:5] == ppe_pkg::MODE_TEST);
  cov_err_irq: cover property (error_irq_o);
  cov_addr_cycle: cover property ($fell(ctl_pins_o.select_in_n) && !ctl_pins_o.data_strobe_n);
endmodule : ppe_port_chk

bind ppe_port ppe_port_chk #(.EPP_TIMEOUT_CYCLES(EPP_TIMEOUT_CYCLES)) u_chk (
  .clock_i(clock_i),
  .resetn_i(resetn_i),
  .bus_i(bus_i),
  .rdata_o(rdata_o),
  .pins_i(pins_i),
  .ctl_pins_o(ctl_pins_o),
  .port_data_out_o(port_data_out_o),
  .port_data_oe_o(port_data_oe_o),
  .dma_tc_i(dma_tc_i),
  .dma_req_o(dma_req_o),
  .error_irq_o(error_irq_o)
);

// [ppe_periph.sv]
`timescale 1ns/1ps
module ppe_periph #(
  parameter int DELAY = 6
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire ppe_pkg::ppe_ctl_pins_t ctl_pins_i,
  input wire logic [7:0] port_data_out_i,
  input wire logic port_data_oe_i,
  input wire logic mute_i,
  input wire logic acknowledge_n_i,
  input wire logic fault_n_i,
  input wire logic irq_line_i,
  input wire logic [7:0] reply_i,
  output ppe_pkg::ppe_pins_t pins_o
);
  logic act;
  logic act_q;
  logic ds_q;
  logic start;
  logic busy;
  int pend;
  int cnt;
  logic [11:0] log_q[$];
  assign act = !ctl_pins_i.data_strobe_n || !ctl_pins_i.auto_feed_n || !ctl_pins_i.select_in_n;
  assign start = !mute_i && ((act && !act_q) || (!ctl_pins_i.data_strobe_n && ds_q));
  // Strobes that arrive while busy is still high are queued, so a fast host never deadlocks us.
  assign busy = pend > 0 && cnt >= DELAY;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      act_q <= 1'b0;
      ds_q <= 1'b1;
      pend <= 0;
      cnt <= 0;
    end
    else
    begin
      act_q <= act;
      ds_q <= ctl_pins_i.data_strobe_n;
      pend <= pend + int'(start) - int'(cnt == 2 * DELAY);
      cnt <= (pend == 0 || cnt == 2 * DELAY) ? 0 : cnt + 1;
      if (start)
        log_q.push_back({port_data_oe_i, ctl_pins_i.select_in_n, ctl_pins_i.auto_feed_n,
                         ctl_pins_i.data_strobe_n, port_data_out_i});
    end
  end

  // The data lines show the inverse of the reply while the host drives them.
  assign pins_o = '{busy_n: busy, acknowledge_n: acknowledge_n_i, paper_out: 1'b0, selected: 1'b1,
                    fault_n: fault_n_i, pin_interrupt_line: irq_line_i,
                    port_data_in: port_data_oe_i ? ~reply_i : reply_i};
endmodule : ppe_periph

// [test_ppe_port.sv]
`timescale 1ns/1ps
module test_ppe_port;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  ppe_pkg::ppe_bus_req_t bus = '0;
  ppe_pkg::ppe_pins_t pins;
  ppe_pkg::ppe_ctl_pins_t ctl;
  logic [7:0] rdata;
  logic [7:0] pdo;
  logic [7:0] reply = 8'h3C;
  logic [7:0] d;
  logic oe;
  logic dma_req;
  logic err_irq;
  logic dma_tc = 1'b0;
  logic mute = 1'b0;
  logic ack_n = 1'b1;
  logic fault_n = 1'b1;
  logic irq_line = 1'b1;
  int errors = 0;
  int tests_run = 0;
  int irq_cnt = 0;
  int base;
  logic [2:0] modes [6] = '{ppe_pkg::MODE_COMPAT, ppe_pkg::MODE_BYTE, ppe_pkg::MODE_COMPAT_FIFO,
                            ppe_pkg::MODE_ECP, ppe_pkg::MODE_TEST, ppe_pkg::MODE_CONFIG};

  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (err_irq === 1'b1) irq_cnt++;

  ppe_port #(.EPP_TIMEOUT_CYCLES(50)) dut (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .bus_i(bus),
    .rdata_o(rdata),
    .pins_i(pins),
    .ctl_pins_o(ctl),
    .port_data_out_o(pdo),
    .port_data_oe_o(oe),
    .dma_tc_i(dma_tc),
    .dma_req_o(dma_req),
    .error_irq_o(err_irq)
  );

  ppe_periph per (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .ctl_pins_i(ctl),
    .port_data_out_i(pdo),
    .port_data_oe_i(oe),
    .mute_i(mute),
    .acknowledge_n_i(ack_n),
    .fault_n_i(fault_n),
    .irq_line_i(irq_line),
    .reply_i(reply),
    .pins_o(pins)
  );

  task automatic test_done();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    @(posedge clock_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock_i);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [10:0] a, output logic [7:0] v);
    @(posedge clock_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    bus <= '0;
    #1;
    v = rdata;
  endtask : rd

  task automatic rchk(input logic [10:0] a, input logic [7:0] exp);
    rd(a, d);
    chk({4'h0, d}, {4'h0, exp});
  endtask : rchk

  // Waits for the next transfer the peripheral saw; mask hides bits a read leaves open.
  task automatic log_chk(input logic [11:0] exp, input logic [11:0] mask);
    int k;
    k = 0;
    while (per.log_q.size() == 0 && k < 200)
    begin
      @(posedge clock_i);
      k++;
    end
    chk(per.log_q.size() == 0 ? 12'hFFF : per.log_q.pop_front() & mask, exp);
    cyc(20);
  endtask : log_chk

  initial
  begin
    repeat (20000) @(posedge clock_i);
    errors++;
    test_done();
  end

  initial
  begin
    cyc(8);
    resetn_i <= 1'b1;
    rchk(ppe_pkg::OFS_CTRL, 8'h00);
    rchk(ppe_pkg::OFS_ECR, 8'h01);
    foreach (modes[i])
    begin
      wr(ppe_pkg::OFS_ECR, {modes[i], 5'h00});
      wr(ppe_pkg::OFS_CTRL, 8'h04);
      rchk(ppe_pkg::OFS_CTRL, 8'h04);
      rd(ppe_pkg::OFS_ECR, d);
      chk({9'h000, d[7:5]}, {9'h000, modes[i]});
    end
    rchk(ppe_pkg::OFS_FIFO, ppe_pkg::ECP_CONFIG_A_VALUE);
    rchk(ppe_pkg::OFS_ECP_CONFIG_B, 8'h40);
    cyc(1);
    irq_line <= 1'b0;
    cyc(3);
    rchk(ppe_pkg::OFS_ECP_CONFIG_B, 8'h00);
    wr(11'h200, 8'hFF);
    rchk(11'h200, 8'h00);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_TEST, 5'h00});
    for (int i = 0; i < 17; i++)
      wr(ppe_pkg::OFS_FIFO, 8'hA0 + i[7:0]);
    rchk(ppe_pkg::OFS_ECR, 8'hC2);
    for (int i = 0; i < 16; i++)
      rchk(ppe_pkg::OFS_FIFO, 8'hA0 + i[7:0]);
    rchk(ppe_pkg::OFS_ECR, 8'hC1);
    rchk(ppe_pkg::OFS_FIFO, 8'hA0);
    wr(ppe_pkg::OFS_FIFO, 8'h55);
    wr(ppe_pkg::OFS_FIFO, 8'h66);
    rchk(ppe_pkg::OFS_FIFO, 8'h55);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_BYTE, 5'h00});
    rchk(ppe_pkg::OFS_ECR, 8'h21);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_TEST, 5'h00});
    rchk(ppe_pkg::OFS_FIFO, 8'h55);
    wr(ppe_pkg::OFS_ECR, 8'h00);
    wr(ppe_pkg::OFS_CTRL, 8'h0B);
    cyc(2);
    chk({8'h00, ctl}, 12'h000);
    wr(ppe_pkg::OFS_CTRL, 8'h04);
    cyc(2);
    chk({7'h00, ctl, oe}, 12'h01F);
    cyc(30);
    per.log_q.delete();
    wr(ppe_pkg::OFS_EPP_ADDR, 8'h5A);
    log_chk(12'hA5A, 12'hFFF);
    wr(ppe_pkg::OFS_EPP_DATA_LO, 8'hC3);
    log_chk(12'hCC3, 12'hFFF);
    rd(ppe_pkg::OFS_EPP_ADDR, d);
    log_chk(12'h300, 12'h700);
    rd(ppe_pkg::OFS_EPP_DATA_LO, d);
    log_chk(12'h500, 12'h700);
    rchk(ppe_pkg::OFS_EPP_ADDR, 8'h3C);
    log_chk(12'h300, 12'h700);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_BYTE, 5'h00});
    wr(ppe_pkg::OFS_CTRL, 8'h24);
    cyc(2);
    chk({11'h000, oe}, 12'h000);
    wr(ppe_pkg::OFS_EPP_DATA_HI, 8'h77);
    log_chk(12'h500, 12'h700);
    wr(ppe_pkg::OFS_CTRL, 8'h04);
    mute <= 1'b1;
    wr(ppe_pkg::OFS_EPP_DATA_LO, 8'h11);
    cyc(80);
    rd(ppe_pkg::OFS_STAT, d);
    chk({9'h000, d[2:0]}, 12'h001);
    mute <= 1'b0;
    wr(ppe_pkg::OFS_EPP_DATA_LO, 8'h22);
    cyc(40);
    chk(12'(per.log_q.size()), 12'h000);
    wr(ppe_pkg::OFS_STAT, 8'h00);
    rd(ppe_pkg::OFS_STAT, d);
    chk({11'h000, d[0]}, 12'h000);
    wr(ppe_pkg::OFS_EPP_DATA_LO, 8'h33);
    log_chk(12'hC33, 12'hFFF);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_ECP, 5'h00});
    wr(ppe_pkg::OFS_DATA, 8'h85);
    wr(ppe_pkg::OFS_FIFO, 8'h42);
    log_chk(12'hC85, 12'hFFF);
    log_chk(12'hE42, 12'hFFF);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_COMPAT_FIFO, 5'h00});
    wr(ppe_pkg::OFS_FIFO, 8'h99);
    log_chk(12'hE99, 12'hFFF);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_ECP, 5'h00});
    wr(ppe_pkg::OFS_CTRL, 8'h24);
    // The peripheral answers only once the host has let go of the data lines.
    cyc(3);
    chk({11'h000, oe}, 12'h000);
    reply <= 8'h6E;
    ack_n <= 1'b0;
    cyc(10);
    ack_n <= 1'b1;
    cyc(10);
    wr(ppe_pkg::OFS_ECR, {ppe_pkg::MODE_TEST, 5'h00});
    rchk(ppe_pkg::OFS_FIFO, 8'h6E);
    wr(ppe_pkg::OFS_ECR, 8'h00);
    base = irq_cnt;
    fault_n <= 1'b0;
    cyc(10);
    chk(12'(irq_cnt - base), 12'h001);
    fault_n <= 1'b1;
    wr(ppe_pkg::OFS_ECR, 8'h10);
    fault_n <= 1'b0;
    cyc(10);
    chk(12'(irq_cnt - base), 12'h001);
    fault_n <= 1'b1;
    wr(ppe_pkg::OFS_CTRL, 8'h04);
    wr(ppe_pkg::OFS_ECR, 8'h48);
    cyc(3);
    chk({11'h000, dma_req}, 12'h001);
    @(posedge clock_i);
    dma_tc <= 1'b1;
    @(posedge clock_i);
    dma_tc <= 1'b0;
    cyc(3);
    chk({11'h000, dma_req}, 12'h000);
    rchk(ppe_pkg::OFS_ECR, 8'h4D);
    test_done();
  end
endmodule : test_ppe_port
